//--- hw/idf_defs.svh
// Offsets, field positions, reset values and timing figures of the isolated DIO core.
`ifndef IDF_DEFS_SVH
`define IDF_DEFS_SVH

// Register window: upper address bits match the host-assigned base.
`define IDF_WIN_LSB        8
`define IDF_OFF_DIN        8'h00
`define IDF_OFF_FILT_EN    8'h04
`define IDF_OFF_FILT_INTV  8'h08
`define IDF_OFF_RISE_EN    8'h0c
`define IDF_OFF_FALL_EN    8'h10
`define IDF_OFF_CHG_STAT   8'h14
`define IDF_OFF_DOUT       8'h18
`define IDF_OFF_PWRUP      8'h1c
`define IDF_OFF_SAFE       8'h20
`define IDF_OFF_WD_TMO     8'h24
`define IDF_OFF_WD_CTRL    8'h28

// Field positions.
`define IDF_STAT_EVT_BIT   0
`define IDF_STAT_OVF_BIT   1
`define IDF_WD_ARM_BIT     0
`define IDF_WD_KICK_BIT    1
`define IDF_WD_EXP_BIT     2

// Timing figures.
`define IDF_CLK_NS         20
`define IDF_SAMPLE_NS      100
`define IDF_SAMPLE_DIV     (`IDF_SAMPLE_NS / `IDF_CLK_NS)
`define IDF_INTV_MIN_US    200
`define IDF_INTV_TOP_MS    200
`define IDF_INTV_MIN_TICKS ((`IDF_INTV_MIN_US * 1000) / `IDF_SAMPLE_NS)
`define IDF_INTV_TOP_TICKS ((`IDF_INTV_TOP_MS * 1000000) / `IDF_SAMPLE_NS)
`define IDF_PWRUP_RESP_MS  400
`define IDF_PWRUP_CYC      ((`IDF_PWRUP_RESP_MS * 1000000) / `IDF_CLK_NS)

// Reset values.
`define IDF_INTV_RST       `IDF_INTV_MIN_TICKS
`define IDF_WD_TMO_RST     32'hffff_ffff

`endif

//--- hw/idf_pkg.sv
// Types shared by the isolated DIO core.
`default_nettype none
package idf_pkg;
   typedef enum logic [2:0] {
      IDF_OUT_OFF  = 3'b001,
      IDF_OUT_RUN  = 3'b010,
      IDF_OUT_SAFE = 3'b100
   } idf_out_st_t;
endpackage
`default_nettype wire

//--- hw/idf_sync3.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`default_nettype none
module idf_sync3 #(
   parameter int W = 32
) (
   input  wire logic         ref_clk_i, // System clock.
   input  wire logic         rst_n_i,   // Asynchronous reset, active low.
   input  wire logic [W-1:0] d_i,       // Pin levels.
   output logic      [W-1:0] q_o        // Synchronised levels.
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] q_reg;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= d_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q_reg <= '0;
      end else begin
         q_reg <= (s2_reg & ~(s2_reg ^ s3_reg)) | (q_reg & (s2_reg ^ s3_reg));
      end
   end

   assign q_o = q_reg;
endmodule // idf_sync3
`default_nettype wire

//--- hw/idf_filter.sv
// Per-line glitch filter clocked by the sample and filter tick enables.
`default_nettype none
module idf_filter #(
   parameter int W = 32
) (
   input  wire logic         ref_clk_i,     // System clock.
   input  wire logic         rst_n_i,       // Asynchronous reset, active low.
   input  wire logic         sample_tick_i, // 100 ns sample enable.
   input  wire logic         filt_tick_i,   // Filter clock enable.
   input  wire logic [W-1:0] en_i,          // Filter select per line.
   input  wire logic [W-1:0] d_i,           // Synchronised lines.
   output logic      [W-1:0] q_o            // Line values after optional filter.
);
   logic [W-1:0] samp_reg;
   logic [W-1:0] cand_reg;
   logic [W-1:0] glitch_reg;
   logic [W-1:0] filt_reg;
   logic [W-1:0] keep;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         samp_reg <= '0;
      end else if (sample_tick_i) begin
         samp_reg <= d_i;
      end
   end

   // A level must hold with no disturbance from one filter edge to the next.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cand_reg   <= '0;
         glitch_reg <= '0;
      end else if (filt_tick_i) begin
         cand_reg   <= samp_reg;
         glitch_reg <= '0;
      end else if (sample_tick_i) begin
         glitch_reg <= glitch_reg | (d_i ^ cand_reg);
      end
   end

   assign keep = glitch_reg | (samp_reg ^ cand_reg);

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         filt_reg <= '0;
      end else if (filt_tick_i) begin
         filt_reg <= (filt_reg & keep) | (cand_reg & ~keep);
      end
   end

   assign q_o = (filt_reg & en_i) | (samp_reg & ~en_i);

   AST_FILT_ONLY_ON_TICK: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !$past(filt_tick_i) |-> $stable(filt_reg))
      else $error("Filtered value changed without a filter clock edge.");
endmodule // idf_filter
`default_nettype wire

//--- hw/idf_top.sv
// Isolated digital I/O core: filtered inputs, change detection, outputs and watchdog.
//
// How it works
// - Filter blocks pulses under half the interval and passes pulses over it.
// - Pass and block widths follow the interval, with photocoupler skew on top.
// - Filtering is chosen per line; all filtered lines share one interval.
// - Every input line is sampled each 100 ns sample tick.
// - A counter makes the filter clock at half the filter interval.
// - A new level counts only after two consecutive steady filter clock edges.
// - Rising and falling changes filter alike, with up to one interval latency.
// - Drivers are off at power-up, then lines take their power-up states.
// - Power-up states take effect within 400 ms.
// - Per-line rising and falling enables; any enabled edge raises the interrupt.
// - One shared change flag, no record of which line or which edge.
// - A further edge before service sets the overflow bit.
// - Lines watched for change read hidden until a change event has happened.
// - Armed watchdog not refreshed in time forces outputs to safe states.
// - Safe states hold until disarm plus new write, or reset.
// - Expiry indication stays on from expiry until the watchdog is disarmed.
// - After expiry, output writes are dropped until the watchdog is disarmed.
// - Watchdog timeout is a 32-bit count of 100 ns ticks.
// - Registers decode from a host-assigned base address, no straps.
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`include "idf_defs.svh"
`default_nettype none
module idf_top
   import idf_pkg::*;
#(
   parameter int          N_IN          = 32,
   parameter int          N_OUT         = 32,
   parameter int          PWRUP_CYC     = `IDF_PWRUP_CYC,
   parameter logic [31:0] PWRUP_DEFAULT = 32'h0000_0000,
   parameter logic [31:0] SAFE_DEFAULT  = 32'h0000_0000
) (
   input  wire logic             ref_clk_i,     // 50 MHz system clock.
   input  wire logic             rst_n_i,       // Asynchronous reset, active low.
   input  wire logic [31:0]      bar_base_i,    // Base address assigned by the host.
   input  wire logic [31:0]      addr_i,        // Register byte address.
   input  wire logic [31:0]      wdata_i,       // Write data.
   input  wire logic             wr_i,          // Write strobe.
   input  wire logic             rd_i,          // Read strobe.
   output logic      [31:0]      rdata_o,       // Read data, cycle after the strobe.
   input  wire logic [N_IN-1:0]  din_i,         // Input lines from the photocouplers.
   output logic      [N_OUT-1:0] dout_o,        // Output line levels.
   output logic                  dout_oe_o,     // Output driver enable.
   output logic                  chg_irq_o,     // Change-detection interrupt.
   output logic                  wd_expired_o   // Watchdog expired indication.
);
   localparam int IW = 21;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   logic [N_IN-1:0]  filt_en_reg;
   logic [IW-1:0]    intv_reg;
   logic [N_IN-1:0]  rise_en_reg;
   logic [N_IN-1:0]  fall_en_reg;
   logic [N_IN-1:0]  prev_reg;
   logic             evt_reg;
   logic             ovf_reg;
   logic             seen_reg;
   logic [N_OUT-1:0] dout_reg;
   logic [N_OUT-1:0] pwrup_reg;
   logic [N_OUT-1:0] safe_reg;
   logic             oe_reg;
   logic [31:0]      wd_tmo_reg;
   logic [31:0]      wd_cnt_reg;
   logic             wd_arm_reg;
   logic             wd_exp_reg;
   idf_out_st_t      st_reg;
   logic [31:0]      pwr_cnt_reg;
   logic [2:0]       div_cnt_reg;
   logic             tick_reg;
   logic [IW-1:0]    fcnt_reg;
   logic             ftick_reg;
   logic [31:0]      rdata_reg;
   logic [31:0]      rdata_next;
   logic [N_IN-1:0]  sync_val;
   logic [N_IN-1:0]  line_val;
   logic [N_IN-1:0]  edges;
   logic [IW-1:0]    intv_next;
   logic [IW-1:0]    half_intv;
   logic             edge_any;
   logic             stat_rd;
   logic             din_wr_en;
   logic             dout_wr;
   logic             wd_ctrl_wr;
   logic             arm_start;
   logic             disarm;
   logic             kick;
   logic             wd_fire;
   logic             pwr_done;

   // Address match inside the window that the host placed.
   function automatic logic hit(input logic [31:0] a, input logic [31:0] base,
                                input logic [7:0] off);
      return (a[31:`IDF_WIN_LSB] == base[31:`IDF_WIN_LSB]) &&
             (a[`IDF_WIN_LSB-1:0] == off);
   endfunction

   assign stat_rd    = rd_i & hit(addr_i, bar_base_i, `IDF_OFF_CHG_STAT);
   assign din_wr_en  = wr_i & (hit(addr_i, bar_base_i, `IDF_OFF_RISE_EN) |
                               hit(addr_i, bar_base_i, `IDF_OFF_FALL_EN));
   assign dout_wr    = wr_i & hit(addr_i, bar_base_i, `IDF_OFF_DOUT);
   assign wd_ctrl_wr = wr_i & hit(addr_i, bar_base_i, `IDF_OFF_WD_CTRL);
   assign disarm     = wd_ctrl_wr & ~wdata_i[`IDF_WD_ARM_BIT];
   assign arm_start  = wd_ctrl_wr & wdata_i[`IDF_WD_ARM_BIT] & ~wd_arm_reg;
   assign kick       = wd_ctrl_wr & wdata_i[`IDF_WD_ARM_BIT] & wdata_i[`IDF_WD_KICK_BIT]
                       & wd_arm_reg & ~wd_exp_reg;
   assign wd_fire    = wd_arm_reg & ~wd_exp_reg & tick_reg & (wd_cnt_reg == 32'h0) & ~kick;
   assign pwr_done   = (st_reg == IDF_OUT_OFF) && (pwr_cnt_reg == 32'(PWRUP_CYC - 1));

   // Sample clock: one enable pulse every 100 ns.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_cnt_reg <= 3'h0;
         tick_reg    <= 1'b0;
      end else if (div_cnt_reg == 3'(`IDF_SAMPLE_DIV - 1)) begin
         div_cnt_reg <= 3'h0;
         tick_reg    <= 1'b1;
      end else begin
         div_cnt_reg <= div_cnt_reg + 3'h1;
         tick_reg    <= 1'b0;
      end
   end

   // Interval writes are clamped to the supported range.
   always_comb begin
      if (wdata_i < 32'(`IDF_INTV_MIN_TICKS)) begin
         intv_next = IW'(`IDF_INTV_MIN_TICKS);
      end else if (wdata_i > 32'(`IDF_INTV_TOP_TICKS)) begin
         intv_next = IW'(`IDF_INTV_TOP_TICKS);
      end else begin
         intv_next = wdata_i[IW-1:0];
      end
   end

   assign half_intv = intv_reg >> 1;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         filt_en_reg <= '0;
         intv_reg    <= IW'(`IDF_INTV_RST);
      end else if (wr_i) begin
         if (hit(addr_i, bar_base_i, `IDF_OFF_FILT_EN)) begin
            filt_en_reg <= wdata_i[N_IN-1:0];
         end
         if (hit(addr_i, bar_base_i, `IDF_OFF_FILT_INTV)) begin
            intv_reg <= intv_next;
         end
      end
   end

   // Filter clock: half the interval counted in sample ticks.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fcnt_reg  <= '0;
         ftick_reg <= 1'b0;
      end else if (wr_i && hit(addr_i, bar_base_i, `IDF_OFF_FILT_INTV)) begin
         fcnt_reg  <= (intv_next >> 1) - IW'(1);
         ftick_reg <= 1'b0;
      end else if (tick_reg && fcnt_reg == '0) begin
         fcnt_reg  <= half_intv - IW'(1);
         ftick_reg <= 1'b1;
      end else begin
         fcnt_reg  <= tick_reg ? fcnt_reg - IW'(1) : fcnt_reg;
         ftick_reg <= 1'b0;
      end
   end

   idf_sync3 #(.W(N_IN)) u_sync (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .d_i       (din_i),
      .q_o       (sync_val)
   );

   idf_filter #(.W(N_IN)) u_filter (
      .ref_clk_i     (ref_clk_i),
      .rst_n_i       (rst_n_i),
      .sample_tick_i (tick_reg),
      .filt_tick_i   (ftick_reg),
      .en_i          (filt_en_reg),
      .d_i           (sync_val),
      .q_o           (line_val)
   );

   // Change detection on the line values after the filter.
   assign edges    = (line_val & ~prev_reg & rise_en_reg) |
                     (~line_val & prev_reg & fall_en_reg);
   assign edge_any = |edges;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev_reg    <= '0;
         rise_en_reg <= '0;
         fall_en_reg <= '0;
      end else begin
         prev_reg <= line_val;
         if (wr_i && hit(addr_i, bar_base_i, `IDF_OFF_RISE_EN)) begin
            rise_en_reg <= wdata_i[N_IN-1:0];
         end
         if (wr_i && hit(addr_i, bar_base_i, `IDF_OFF_FALL_EN)) begin
            fall_en_reg <= wdata_i[N_IN-1:0];
         end
      end
   end

   // A new edge in the clearing cycle wins over the clear.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         evt_reg <= 1'b0;
         ovf_reg <= 1'b0;
      end else begin
         evt_reg <= edge_any | (evt_reg & ~stat_rd);
         ovf_reg <= (edge_any & evt_reg & ~stat_rd) | (ovf_reg & ~stat_rd);
      end
   end

   // Watched lines become visible once an event has been raised.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         seen_reg <= 1'b0;
      end else if (edge_any) begin
         seen_reg <= 1'b1;
      end else if (din_wr_en) begin
         seen_reg <= 1'b0;
      end
   end

   // Power-up, safe-state and watchdog configuration.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwrup_reg  <= PWRUP_DEFAULT[N_OUT-1:0];
         safe_reg   <= SAFE_DEFAULT[N_OUT-1:0];
         wd_tmo_reg <= `IDF_WD_TMO_RST;
      end else if (wr_i) begin
         if (hit(addr_i, bar_base_i, `IDF_OFF_PWRUP)) begin
            pwrup_reg <= wdata_i[N_OUT-1:0];
         end
         if (hit(addr_i, bar_base_i, `IDF_OFF_SAFE)) begin
            safe_reg <= wdata_i[N_OUT-1:0];
         end
         if (hit(addr_i, bar_base_i, `IDF_OFF_WD_TMO)) begin
            wd_tmo_reg <= wdata_i;
         end
      end
   end

   // Watchdog: 32-bit countdown in 100 ns ticks.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wd_arm_reg <= 1'b0;
         wd_exp_reg <= 1'b0;
         wd_cnt_reg <= 32'h0;
      end else if (disarm) begin
         // An expiry in the disarm cycle still stands, so flag and safe outputs agree.
         wd_arm_reg <= 1'b0;
         wd_exp_reg <= wd_fire;
      end else if (arm_start || kick) begin
         wd_arm_reg <= 1'b1;
         wd_cnt_reg <= wd_tmo_reg;
      end else if (wd_fire) begin
         wd_exp_reg <= 1'b1;
      end else if (wd_arm_reg && !wd_exp_reg && tick_reg) begin
         wd_cnt_reg <= wd_cnt_reg - 32'h1;
      end
   end

   // Power-up wait before the drivers are enabled.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwr_cnt_reg <= 32'h0;
      end else if (st_reg == IDF_OUT_OFF && !pwr_done) begin
         pwr_cnt_reg <= pwr_cnt_reg + 32'h1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_reg   <= IDF_OUT_OFF;
         oe_reg   <= 1'b0;
         dout_reg <= '0;
      end else begin
         unique case (st_reg)
            IDF_OUT_OFF: begin
               if (pwr_done) begin
                  st_reg   <= IDF_OUT_RUN;
                  oe_reg   <= 1'b1;
                  dout_reg <= pwrup_reg;
               end
            end
            IDF_OUT_RUN: begin
               // An expiry that struck before the drivers came up still forces safe states.
               if (wd_fire || wd_exp_reg) begin
                  st_reg   <= IDF_OUT_SAFE;
                  dout_reg <= safe_reg;
               end else if (dout_wr) begin
                  dout_reg <= wdata_i[N_OUT-1:0];
               end
            end
            IDF_OUT_SAFE: begin
               if (!wd_arm_reg && !wd_exp_reg && dout_wr) begin
                  st_reg   <= IDF_OUT_RUN;
                  dout_reg <= wdata_i[N_OUT-1:0];
               end else begin
                  dout_reg <= safe_reg;
               end
            end
         endcase
      end
   end

   // Read mux; unmapped addresses read zero.
   always_comb begin
      rdata_next = 32'h0;
      if (rd_i) begin
         if (hit(addr_i, bar_base_i, `IDF_OFF_DIN)) begin
            rdata_next = 32'(line_val & (~(rise_en_reg | fall_en_reg) | {N_IN{seen_reg}}));
         end else if (hit(addr_i, bar_base_i, `IDF_OFF_FILT_EN)) begin
            rdata_next = 32'(filt_en_reg);
         end else if (hit(addr_i, bar_base_i, `IDF_OFF_FILT_INTV)) begin
            rdata_next = 32'(intv_reg);
         end else if (hit(addr_i, bar_base_i, `IDF_OFF_RISE_EN)) begin
            rdata_next = 32'(rise_en_reg);
         end else if (hit(addr_i, bar_base_i, `IDF_OFF_FALL_EN)) begin
            rdata_next = 32'(fall_en_reg);
         end else if (stat_rd) begin
            rdata_next[`IDF_STAT_EVT_BIT] = evt_reg;
            rdata_next[`IDF_STAT_OVF_BIT] = ovf_reg;
         end else if (hit(addr_i, bar_base_i, `IDF_OFF_DOUT)) begin
            rdata_next = 32'(dout_reg);
         end else if (hit(addr_i, bar_base_i, `IDF_OFF_PWRUP)) begin
            rdata_next = 32'(pwrup_reg);
         end else if (hit(addr_i, bar_base_i, `IDF_OFF_SAFE)) begin
            rdata_next = 32'(safe_reg);
         end else if (hit(addr_i, bar_base_i, `IDF_OFF_WD_TMO)) begin
            rdata_next = wd_tmo_reg;
         end else if (hit(addr_i, bar_base_i, `IDF_OFF_WD_CTRL)) begin
            rdata_next[`IDF_WD_ARM_BIT] = wd_arm_reg;
            rdata_next[`IDF_WD_EXP_BIT] = wd_exp_reg;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_reg <= 32'h0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign rdata_o      = rdata_reg;
   assign dout_o       = dout_reg;
   assign dout_oe_o    = oe_reg;
   assign chg_irq_o    = evt_reg;
   assign wd_expired_o = wd_exp_reg;

   sequence s_wd_fire;
      wd_arm_reg && !wd_exp_reg && tick_reg && wd_cnt_reg == 32'h0 && !wd_ctrl_wr;
   endsequence
   sequence s_safe_out;
      wd_expired_o ##1 (st_reg == IDF_OUT_SAFE || $past(st_reg) == IDF_OUT_OFF);
   endsequence

   AST_WD_FORCES_SAFE: assert property (s_wd_fire |=> s_safe_out)
      else $error("Watchdog expiry did not force the safe state.");
   AST_WD_EXP_HOLDS: assert property (wd_exp_reg && !disarm |=> wd_exp_reg)
      else $error("Expiry indication dropped before disarm.");
   AST_WD_WRITE_DROPPED: assert property (
      st_reg == IDF_OUT_SAFE && wd_exp_reg && dout_wr |=> st_reg == IDF_OUT_SAFE)
      else $error("Output write accepted while the watchdog is expired.");
   AST_SAFE_VALUE: assert property (
      st_reg == IDF_OUT_SAFE && $stable(safe_reg) ##1 st_reg == IDF_OUT_SAFE
      |-> dout_o == $past(safe_reg))
      else $error("Outputs left the safe values while in the safe state.");
   AST_WD_COUNTS: assert property (
      wd_arm_reg && !wd_exp_reg && tick_reg && wd_cnt_reg != 32'h0 && !wd_ctrl_wr
      |=> wd_cnt_reg == $past(wd_cnt_reg) - 32'h1)
      else $error("Watchdog counter did not step by one tick.");
   AST_EDGE_IRQ: assert property (edge_any |=> chg_irq_o)
      else $error("Enabled edge did not raise the interrupt.");
   AST_OVERFLOW: assert property (evt_reg && edge_any && !stat_rd |=> ovf_reg)
      else $error("Second edge before service did not set overflow.");
   AST_STAT_CLEAR: assert property (stat_rd && !edge_any |=> !chg_irq_o && !ovf_reg)
      else $error("Status read did not clear the change event.");
   AST_HIDDEN_READ: assert property (
      rd_i && hit(addr_i, bar_base_i, `IDF_OFF_DIN) && !seen_reg && !edge_any
      |=> (rdata_o & 32'(rise_en_reg | fall_en_reg)) == 32'h0)
      else $error("Watched line readable before a change event.");
   AST_DRIVERS_OFF: assert property (st_reg == IDF_OUT_OFF |-> !dout_oe_o)
      else $error("Output drivers enabled before power-up completed.");
   AST_PWRUP_LOAD: assert property ($rose(dout_oe_o) |-> dout_o == $past(pwrup_reg))
      else $error("Drivers enabled without the power-up states.");
   AST_INTV_RANGE: assert property (
      intv_reg >= IW'(`IDF_INTV_MIN_TICKS) && intv_reg <= IW'(`IDF_INTV_TOP_TICKS))
      else $error("Filter interval out of range.");
endmodule // idf_top
`default_nettype wire

//--- testbench/tb_line_src.sv
// Field-side model that drives the isolated input lines.
`default_nettype none
module tb_line_src (
   input  wire logic        ref_clk_i, // System clock.
   output var  logic [31:0] din_o      // Line levels seen by the core.
);
   timeunit 1ns;
   timeprecision 1ps;
   initial din_o = 32'h0000_0011;
   task automatic set(input int ln, input logic lv);
      @(posedge ref_clk_i);
      din_o[ln] <= lv;
   endtask
   task automatic pulse(input int ln, input int cyc);
      set(ln, 1'b1);
      repeat (cyc) @(posedge ref_clk_i);
      din_o[ln] <= 1'b0;
   endtask
endmodule // tb_line_src
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench of the isolated DIO core.
`include "idf_defs.svh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int          PW   = 50;
   localparam int          IV   = `IDF_INTV_MIN_TICKS * `IDF_SAMPLE_DIV;
   localparam logic [31:0] PUD  = 32'h0000_00a5;
   localparam logic [31:0] SFD  = 32'h0000_5a00;
   localparam logic [31:0] BASE = 32'hc000_0000;
   logic        clk, rst_n, wr, rd, oe, irq, wdx;
   logic [31:0] addr, wdata, rdata, din, dout, v;
   int          fail_count, num_checks;
   tb_line_src src (.ref_clk_i(clk), .din_o(din));
   idf_top #(.PWRUP_CYC(PW), .PWRUP_DEFAULT(PUD), .SAFE_DEFAULT(SFD)) uut (
      .ref_clk_i(clk), .rst_n_i(rst_n), .bar_base_i(BASE), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .din_i(din),
      .dout_o(dout), .dout_oe_o(oe), .chg_irq_o(irq), .wd_expired_o(wdx));
   function automatic logic [31:0] vis(input logic [31:0] d, input logic [31:0] m);
      return d & ~m;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   task automatic wr32(input logic [7:0] off, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= BASE | off;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd32(input logic [31:0] a, output logic [31:0] q);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      q = rdata;
   endtask
   task automatic conclude();
      $display("checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      conclude();
   end
   initial begin
      rst_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = '0;
      wdata = '0;
      fail_count = 0;
      num_checks = 0;
      v = $urandom(27);
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(negedge clk);
      chk("oe early", 32'h0, {31'h0, oe});
      repeat (PW + 5) @(negedge clk);
      chk("oe", 32'h1, {31'h0, oe});
      chk("powerup", PUD, dout);
      wr32(`IDF_OFF_RISE_EN, 32'h3);
      wr32(`IDF_OFF_FALL_EN, 32'h2);
      rd32(BASE | `IDF_OFF_DIN, v);
      chk("din hidden", vis(32'h11, 32'h3), v);
      rd32(BASE | 32'h80, v);
      chk("unmapped", 32'h0, v);
      rd32(32'h4000_0000 | `IDF_OFF_WD_TMO, v);
      chk("off window", 32'h0, v);
      rd32(BASE | `IDF_OFF_WD_TMO, v);
      chk("tmo reset", `IDF_WD_TMO_RST, v);
      src.set(4, 1'b0);
      repeat (20) @(negedge clk);
      chk("no event", 32'h0, {31'h0, irq});
      src.set(1, 1'b1);
      for (int i = 0; i < 30 && irq !== 1'b1; i++) @(negedge clk);
      chk("rise event", 32'h1, {31'h0, irq});
      rd32(BASE | `IDF_OFF_DIN, v);
      chk("din shown", vis(32'h3, 32'h0), v);
      src.set(1, 1'b0);
      repeat (20) @(posedge clk);
      rd32(BASE | `IDF_OFF_CHG_STAT, v);
      chk("status", 32'h3, v);
      chk("irq cleared", 32'h0, {31'h0, irq});
      rd32(BASE | `IDF_OFF_CHG_STAT, v);
      chk("status cleared", 32'h0, v);
      wr32(`IDF_OFF_FILT_INTV, 32'hffff_ffff);
      rd32(BASE | `IDF_OFF_FILT_INTV, v);
      chk("intv clamp", `IDF_INTV_TOP_TICKS, v);
      wr32(`IDF_OFF_FILT_EN, 32'h4);
      wr32(`IDF_OFF_FILT_INTV, `IDF_INTV_MIN_TICKS);
      wr32(`IDF_OFF_RISE_EN, 32'h4);
      wr32(`IDF_OFF_FALL_EN, 32'h4);
      src.pulse(2, IV / 4);
      repeat (IV + 100) @(negedge clk);
      chk("short pulse", 32'h0, {31'h0, irq});
      for (int k = 0; k < 2; k++) begin
         rd32(BASE | `IDF_OFF_CHG_STAT, v);
         src.set(2, k == 0);
         repeat (IV / 2 - 50) @(negedge clk);
         chk("filter early", 32'h0, {31'h0, irq});
         repeat (IV / 2 + 100) @(negedge clk);
         chk("filter late", 32'h1, {31'h0, irq});
      end
      repeat (4) begin
         v = $urandom;
         wr32(`IDF_OFF_DOUT, v);
         @(negedge clk);
         chk("dout", v, dout);
      end
      wr32(`IDF_OFF_WD_TMO, 32'd20);
      wr32(`IDF_OFF_WD_CTRL, 32'h1);
      repeat (4) begin
         repeat (60) @(posedge clk);
         wr32(`IDF_OFF_WD_CTRL, 32'h3);
      end
      chk("refreshed", 32'h0, {31'h0, wdx});
      wr32(`IDF_OFF_WD_CTRL, 32'h0);
      wr32(`IDF_OFF_WD_TMO, 32'h0);
      wr32(`IDF_OFF_WD_CTRL, 32'h1);
      for (int i = 0; i < 20 && wdx !== 1'b1; i++) @(negedge clk);
      repeat (2) @(negedge clk);
      chk("safe", SFD, dout);
      wr32(`IDF_OFF_DOUT, ~SFD);
      @(negedge clk);
      chk("dropped", SFD, dout);
      chk("expired", 32'h1, {31'h0, wdx});
      wr32(`IDF_OFF_WD_CTRL, 32'h0);
      @(negedge clk);
      chk("disarmed", 32'h0, {31'h0, wdx});
      chk("held", SFD, dout);
      wr32(`IDF_OFF_DOUT, v);
      @(negedge clk);
      chk("resumed", v, dout);
      wr32(`IDF_OFF_WD_CTRL, 32'h1);
      for (int i = 0; i < 20 && wdx !== 1'b1; i++) @(negedge clk);
      chk("expired again", 32'h1, {31'h0, wdx});
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk("reset expiry", 32'h0, {31'h0, wdx});
      chk("reset oe", 32'h0, {31'h0, oe});
      repeat (PW + 5) @(negedge clk);
      chk("reset powerup", PUD, dout);
      conclude();
   end
endmodule // tb_top
`default_nettype wire
